// ### stepper_config_status_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * stepper configuration and status block.
 * Assumes it is included by its bare name wherever a figure is needed.
 */
`ifndef STEPPER_CONFIG_STATUS_REGS_SVH
`define STEPPER_CONFIG_STATUS_REGS_SVH

// register offsets
`define ADDR_CTRL_LEVEL     8'h01
`define ADDR_CTRL_MOTION    8'h02
`define ADDR_CTRL_POWER     8'h03
`define ADDR_FAULT_GENERAL  8'h04
`define ADDR_OVERLOAD_X     8'h05

// control level register fields
`define PEAK_LSB            0
`define RES_LSB             5
// control motion register fields
`define DIRINV_BIT          7
`define STEPPOL_BIT         6
`define PWMDBL_BIT          5
`define JITTER_BIT          4
`define SLOPE_LSB           0
// control power register fields
`define DRVEN_BIT           7
`define SLEEP_BIT           6
`define LAGAIN_BIT          5
`define LAHOLD_BIT          4
// status fields
`define CHECK_BIT           7
`define HEAT_BIT            6
`define PUMP_BIT            5
`define OPEN_A_BIT          3
`define OPEN_B_BIT          2
`define OVL_MSB             6
`define OVL_LSB             3

// reset values and reserved resolution code
`define CTRL_RESET          8'h00
`define STATUS_RESET        8'h00
`define LFSR_SEED           8'hA5
`define STEP_RES_RESERVED   3'h7

// timing: clock and base chopping rate in Hz, cycles rounded down
`define CLK_HZ              20000000
`define PWM_BASE_HZ         22800
`define PWM_BASE_CYCLES     (`CLK_HZ / `PWM_BASE_HZ)
`define PWM_FAST_CYCLES     (`CLK_HZ / (2 * `PWM_BASE_HZ))

`endif

// ### stepper_pkg.sv
/*
 * Types of the stepper configuration and status block.
 * Assumes nothing; widths come from the register layout.
 */
package stepper_pkg;

    // state of the top module apart from the input synchroniser, registered as one word
    typedef struct packed {
        logic [4:0] peak_code;
        logic [2:0] step_res;
        logic       dir_invert;
        logic       step_on_fall;
        logic       pwm_double;
        logic       jitter_on;
        logic [1:0] slope_code;
        logic       drive_on;
        logic       sleep;
        logic       la_quarter;
        logic       la_hold;
        logic [7:0] general_status;
        logic [7:0] overload_status;
        logic [7:0] rdata;
        logic       step_prev;
        logic       step_pulse;
        logic       direction;
        logic [10:0] pwm_cnt;
        logic       pwm_tick;
        logic [7:0] lfsr;
        logic [7:0] load_angle;
        logic [9:0] peak_ma;
        logic [7:0] slope_rate;
    } state_t;

endpackage

// ### sync_bits.sv
/*
 * Two-flop synchroniser for a group of independent level inputs.
 * Assumes each bit is a slow level; no bus coherence across bits.
 */
`timescale 1ns/1ns
module sync_bits #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // sync_bits

// ### stepper_config_status.sv
/*
 * Configuration and status logic of a micro-stepping bipolar driver.
 * Assumes a frame decoder on clk presents one register access per strobe
 * and that pins and fault detectors are asynchronous to clk.
 */
`timescale 1ns/1ns
`include "stepper_config_status_regs.svh"
module stepper_config_status (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       dir_pin,
    input  wire logic       step_pulse_in,
    input  wire logic       heat_warning_flag,
    input  wire logic       pump_fail_flag,
    input  wire logic       coil_a_open,
    input  wire logic       coil_b_open,
    input  wire logic [3:0] coil_a_overload,
    input  wire logic [7:0] load_angle_raw,
    output logic      [7:0] load_angle_output,
    output logic            drivers_enable,
    output logic            sleep_mode,
    output logic            pwm_period_start,
    output logic            direction_ccw,
    output logic            step_advance,
    output logic      [4:0] coil_peak_level,
    output logic      [9:0] regulated_peak_current,
    output logic      [1:0] edge_slope_select,
    output logic      [7:0] slope_rate_v_us,
    output logic      [2:0] step_resolution
);
    ////////////////////////////////////////////////////////////////////////
    // tables and reset state
    localparam logic [9:0] PEAK_MA [32] = '{
        10'd15,  10'd30,  10'd45,  10'd50,  10'd55,  10'd61,  10'd67,
        10'd74,  10'd82,  10'd91,  10'd100, 10'd110, 10'd122, 10'd135,
        10'd149, 10'd164, 10'd181, 10'd200, 10'd221, 10'd244, 10'd269,
        10'd297, 10'd328, 10'd362, 10'd400, 10'd441, 10'd487, 10'd538,
        10'd594, 10'd656, 10'd724, 10'd800};
    localparam logic [7:0] SLOPE_V_US [4] = '{8'd150, 8'd100, 8'd50, 8'd25};
    localparam logic [10:0] PWM_BASE = 11'(`PWM_BASE_CYCLES);
    localparam logic [10:0] PWM_FAST = 11'(`PWM_FAST_CYCLES);
    localparam stepper_pkg::state_t RESET_STATE = '{
        peak_code: '0, step_res: '0, dir_invert: 1'b0, step_on_fall: 1'b0,
        pwm_double: 1'b0, jitter_on: 1'b0, slope_code: '0, drive_on: 1'b0,
        sleep: 1'b0, la_quarter: 1'b0, la_hold: 1'b0,
        general_status: `STATUS_RESET, overload_status: `STATUS_RESET,
        rdata: '0, step_prev: 1'b0, step_pulse: 1'b0, direction: 1'b0,
        pwm_cnt: '0, pwm_tick: 1'b0, lfsr: `LFSR_SEED, load_angle: '0,
        peak_ma: 10'd15, slope_rate: 8'd150};

    stepper_pkg::state_t s;
    stepper_pkg::state_t next_s;
    logic [9:0]  pin_sync;
    logic        dir_s;
    logic        step_s;
    logic        step_edge;

    ////////////////////////////////////////////////////////////////////////
    // every pin and fault detector is asynchronous, so all pass two flops; load_angle_raw does not
    // overload bits keep their order so [9:6] lands on status bits 6 to 3
    sync_bits #(.W(10)) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .d      ({coil_a_overload, coil_b_open, coil_a_open,
                  pump_fail_flag, heat_warning_flag, step_pulse_in,
                  dir_pin}),
        .q      (pin_sync)
    );
    assign dir_s  = pin_sync[0];
    assign step_s = pin_sync[1];
    // selected edge of the synced step input
    assign step_edge = s.step_on_fall ? (s.step_prev & ~step_s)
                                      : (~s.step_prev & step_s);

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        next_s = s;
        next_s.step_prev  = step_s;
        next_s.step_pulse = step_edge;
        next_s.direction  = dir_s ^ s.dir_invert;
        // register writes; status offsets are read-only and ignore writes
        if (reg_wr) begin
            case (reg_addr)
                `ADDR_CTRL_LEVEL: begin
                    next_s.peak_code = reg_wdata[`PEAK_LSB +: 5];
                    // reserved resolution code keeps the previous mode
                    if (reg_wdata[`RES_LSB +: 3] != `STEP_RES_RESERVED) begin
                        next_s.step_res = reg_wdata[`RES_LSB +: 3];
                    end
                end
                `ADDR_CTRL_MOTION: begin
                    next_s.dir_invert   = reg_wdata[`DIRINV_BIT];
                    next_s.step_on_fall = reg_wdata[`STEPPOL_BIT];
                    next_s.pwm_double   = reg_wdata[`PWMDBL_BIT];
                    next_s.jitter_on    = reg_wdata[`JITTER_BIT];
                    next_s.slope_code   = reg_wdata[`SLOPE_LSB +: 2];
                end
                `ADDR_CTRL_POWER: begin
                    next_s.drive_on   = reg_wdata[`DRVEN_BIT];
                    next_s.sleep      = reg_wdata[`SLEEP_BIT];
                    next_s.la_quarter = reg_wdata[`LAGAIN_BIT];
                    next_s.la_hold    = reg_wdata[`LAHOLD_BIT];
                end
                default: begin
                end
            endcase
        end
        // general status tracks live detectors, unused bits zero
        next_s.general_status = '0;
        next_s.general_status[`HEAT_BIT]   = pin_sync[2];
        next_s.general_status[`PUMP_BIT]   = pin_sync[3];
        next_s.general_status[`OPEN_A_BIT] = pin_sync[4];
        next_s.general_status[`OPEN_B_BIT] = pin_sync[5];
        next_s.general_status[`CHECK_BIT]  =
            ^next_s.general_status[6:0];
        // overload flags stick; a read clears, but a new event wins
        next_s.overload_status = s.overload_status;
        if (reg_rd && reg_addr == `ADDR_OVERLOAD_X) begin
            next_s.overload_status = '0;
        end
        next_s.overload_status[`OVL_MSB:`OVL_LSB] =
            next_s.overload_status[`OVL_MSB:`OVL_LSB]
            | pin_sync[9:6];
        next_s.overload_status[2:0] = '0;
        next_s.overload_status[`CHECK_BIT] =
            ^next_s.overload_status[6:0];
        // read data registered one cycle after the strobe
        if (reg_rd) begin
            case (reg_addr)
                `ADDR_CTRL_LEVEL: next_s.rdata = {s.step_res, s.peak_code};
                `ADDR_CTRL_MOTION: next_s.rdata = {s.dir_invert,
                    s.step_on_fall, s.pwm_double, s.jitter_on, 2'b00,
                    s.slope_code};
                `ADDR_CTRL_POWER: next_s.rdata = {s.drive_on, s.sleep,
                    s.la_quarter, s.la_hold, 4'h0};
                `ADDR_FAULT_GENERAL: next_s.rdata = s.general_status;
                `ADDR_OVERLOAD_X: next_s.rdata = s.overload_status;
                default: next_s.rdata = 8'h00;
            endcase
        end
        // chop period counter; jitter stretches each period by lfsr bits
        next_s.pwm_tick = 1'b0;
        if (s.pwm_cnt == '0) begin
            next_s.pwm_tick = 1'b1;
            next_s.lfsr = {s.lfsr[6:0],
                           s.lfsr[7] ^ s.lfsr[5] ^ s.lfsr[4] ^ s.lfsr[3]};
            next_s.pwm_cnt = (s.pwm_double ? PWM_FAST : PWM_BASE) - 11'd1
                + (s.jitter_on ? {7'h00, s.lfsr[3:0]} : 11'd0);
        end else begin
            next_s.pwm_cnt = s.pwm_cnt - 11'd1;
        end
        // transparent output follows each sample, else holds per step
        if (!s.la_hold || step_edge) begin
            next_s.load_angle = s.la_quarter ? {2'b00, load_angle_raw[7:2]}
                                : {1'b0, load_angle_raw[7:1]};
        end
        next_s.peak_ma    = PEAK_MA[s.peak_code];
        next_s.slope_rate = SLOPE_V_US[s.slope_code];
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    // outputs all taken from the state register
    assign reg_rdata              = s.rdata;
    assign load_angle_output      = s.load_angle;
    assign drivers_enable         = s.drive_on;
    assign sleep_mode             = s.sleep;
    assign pwm_period_start       = s.pwm_tick;
    assign direction_ccw          = s.direction;
    assign step_advance           = s.step_pulse;
    assign coil_peak_level        = s.peak_code;
    assign regulated_peak_current = s.peak_ma;
    assign edge_slope_select      = s.slope_code;
    assign slope_rate_v_us        = s.slope_rate;
    assign step_resolution        = s.step_res;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence rise_seen;
        !s.step_on_fall && !s.step_prev && step_s;
    endsequence
    sequence fall_seen;
        s.step_on_fall && s.step_prev && !step_s;
    endsequence
    sequence power_write;
        reg_wr && reg_addr == `ADDR_CTRL_POWER;
    endsequence

    AST_STEP_RISE: assert property (rise_seen |=> step_advance)
        else $error("rising step edge not taken");
    AST_STEP_FALL: assert property (fall_seen |=> step_advance)
        else $error("falling step edge not taken");
    AST_DIR: assert property (##1 direction_ccw ==
        ($past(dir_s) ^ $past(s.dir_invert)))
        else $error("direction differs from pin xor invert");
    AST_POWER: assert property (power_write |=> drivers_enable ==
        $past(reg_wdata[7]) && sleep_mode == $past(reg_wdata[6]))
        else $error("power control write not applied");
    AST_RESERVED: assert property (s.general_status[4] == 1'b0
        && s.general_status[1:0] == 2'b00
        && s.overload_status[2:0] == 3'b000)
        else $error("undefined status bit set");
    AST_LATCH: assert property ((s.overload_status[6]
        && !(reg_rd && reg_addr == `ADDR_OVERLOAD_X))
        |=> s.overload_status[6])
        else $error("overload flag lost without read");
    AST_HEAT: assert property (##1 s.general_status[6]
        == $past(pin_sync[2]))
        else $error("heat warning not tracking");
    AST_CHECK: assert property (s.overload_status[7]
        == ^s.overload_status[6:0])
        else $error("overload check bit wrong");
    AST_PWM: assert property (pwm_period_start
        |=> !pwm_period_start [*8])
        else $error("chop ticks too close");
    AST_GAIN: assert property ((!s.la_hold && s.la_quarter)
        |=> load_angle_output == {2'b00, $past(load_angle_raw[7:2])})
        else $error("quarter gain not applied");
    AST_PEAK: assert property (s.peak_code == 5'h1F
        |=> regulated_peak_current == 10'd800)
        else $error("top peak current wrong");
    AST_RES: assert property (step_resolution != 3'h7)
        else $error("reserved resolution in use");

endmodule // stepper_config_status

// ### mcu_model.sv
/*
 * Host model: register strobes, direction pin and step pin.
 * Assumes the bench calls its tasks from a single process.
 */
`timescale 1ns/1ns
module mcu_model (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            dir_pin,
    output logic            step_pulse_in
);
    // idle strobes low from time zero
    initial begin
        reg_wr        = 1'b0;
        reg_rd        = 1'b0;
        reg_addr      = 8'h00;
        reg_wdata     = 8'h00;
        dir_pin       = 1'b0;
        step_pulse_in = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // one write; released lines show the inverse so stale data never helps
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask
    // one read; data taken a cycle and a half after the edge that samples the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        @(negedge clk);
        d = reg_rdata;
    endtask
    // direction level changed just after a rising edge
    task automatic set_dir(input logic lvl);
        @(posedge clk);
        dir_pin <= lvl;
    endtask
    // step level held far beyond the two-cycle minimum
    task automatic step(input logic lvl);
        @(posedge clk);
        step_pulse_in <= lvl;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask
endmodule // mcu_model

// ### stepper_config_status_tb.sv
/*
 * Self-checking bench of the stepper configuration and status block.
 * Assumes mcu_model drives the register port and the step/direction pins.
 */
`timescale 1ns/1ns
`include "stepper_config_status_regs.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
    n_errors++; $display("BAD t=%0t got=%0h exp=%0h", $time, a, e); end end
module stepper_config_status_tb;
    logic       clk = 1'b0;
    logic       arst_n, heat, pump, open_a, open_b;
    logic [3:0] ovl;
    logic [7:0] la_raw, rdata, la_out, slope_v, d;
    logic       reg_wr, reg_rd, dir_pin, step_in, drv_en, sleep_m, pwm_st;
    logic       ccw, step_adv;
    logic [7:0] addr, wdata;
    logic [4:0] peak_lvl;
    logic [9:0] peak_ma;
    logic [1:0] slope_sel;
    logic [2:0] step_res;
    int         n_errors, total_checks, n_steps;
    logic [9:0] ma [32] = '{10'h00F, 10'h01E, 10'h02D, 10'h032, 10'h037,
        10'h03D, 10'h043, 10'h04A, 10'h052, 10'h05B, 10'h064, 10'h06E,
        10'h07A, 10'h087, 10'h095, 10'h0A4, 10'h0B5, 10'h0C8, 10'h0DD,
        10'h0F4, 10'h10D, 10'h129, 10'h148, 10'h16A, 10'h190, 10'h1B9,
        10'h1E7, 10'h21A, 10'h252, 10'h290, 10'h2D4, 10'h320};
    logic [7:0] sl [4] = '{8'h96, 8'h64, 8'h32, 8'h19};

    mcu_model mcu_u (.clk(clk), .reg_rdata(rdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata),
        .dir_pin(dir_pin), .step_pulse_in(step_in));
    stepper_config_status dut_u (.clk(clk), .arst_n(arst_n),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .dir_pin(dir_pin),
        .step_pulse_in(step_in), .heat_warning_flag(heat),
        .pump_fail_flag(pump), .coil_a_open(open_a),
        .coil_b_open(open_b), .coil_a_overload(ovl),
        .load_angle_raw(la_raw), .load_angle_output(la_out),
        .drivers_enable(drv_en), .sleep_mode(sleep_m),
        .pwm_period_start(pwm_st), .direction_ccw(ccw),
        .step_advance(step_adv), .coil_peak_level(peak_lvl),
        .regulated_peak_current(peak_ma), .edge_slope_select(slope_sel),
        .slope_rate_v_us(slope_v), .step_resolution(step_res));

    ////////////////////////////////////////////////////////////////////////
    // clock and accepted-step counter
    always #25 clk = ~clk;
    always @(posedge clk) if (step_adv === 1'b1) n_steps <= n_steps + 1;

    task automatic final_report;
        if (n_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // detector levels, changed just after a rising edge
    task automatic set_det(input logic [3:0] f, input logic [3:0] o);
        @(posedge clk);
        {heat, pump, open_a, open_b} <= f;
        ovl <= o;
    endtask
    task automatic set_la(input logic [7:0] v);
        @(posedge clk);
        la_raw <= v;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        mcu_u.rd(`ADDR_FAULT_GENERAL, d); `CHK(d, 8'h00);
        mcu_u.rd(`ADDR_OVERLOAD_X, d);    `CHK(d, 8'h00);
        `CHK(peak_ma, 10'h00F);
        `CHK(slope_v, 8'h96);
        `CHK({drv_en, sleep_m}, 2'h0);
    endtask
    task automatic t_power;
        mcu_u.wr(`ADDR_CTRL_POWER, 8'h80); settle(2);
        `CHK({drv_en, sleep_m}, 2'h2);
        mcu_u.wr(`ADDR_CTRL_POWER, 8'h4F); settle(2);
        `CHK({drv_en, sleep_m}, 2'h1);
        mcu_u.rd(`ADDR_CTRL_POWER, d); `CHK(d, 8'h40);
    endtask
    // every peak code, resolution cycling through its legal codes
    task automatic t_level;
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < 32; i++) begin
            mcu_u.wr(`ADDR_CTRL_LEVEL, {r, 5'(i)}); settle(3);
            `CHK(peak_ma, ma[i]);
            `CHK(peak_lvl, 5'(i));
            `CHK(step_res, r);
            r = (r == 3'h6) ? 3'h0 : r + 3'h1;
        end
    endtask
    task automatic t_slope;
        for (int i = 0; i < 4; i++) begin
            mcu_u.wr(`ADDR_CTRL_MOTION, {6'h00, 2'(i)}); settle(3);
            `CHK(slope_v, sl[i]);
            `CHK(slope_sel, 2'(i));
        end
    endtask
    task automatic t_dir;
        for (int k = 0; k < 4; k++) begin
            mcu_u.set_dir(k[0]);
            mcu_u.wr(`ADDR_CTRL_MOTION, {k[1], 7'h00}); settle(5);
            `CHK(ccw, k[0] ^ k[1]);
        end
    endtask
    // opposite-polarity edges must not advance
    task automatic t_step;
        int s0;
        mcu_u.wr(`ADDR_CTRL_MOTION, 8'h00); mcu_u.step(1'b0);
        s0 = n_steps;
        mcu_u.step(1'b1); `CHK(n_steps - s0, 1);
        mcu_u.step(1'b0); `CHK(n_steps - s0, 1);
        mcu_u.wr(`ADDR_CTRL_MOTION, 8'h40);
        mcu_u.step(1'b1); `CHK(n_steps - s0, 1);
        mcu_u.step(1'b0); `CHK(n_steps - s0, 2);
    endtask
    task automatic t_la;
        mcu_u.wr(`ADDR_CTRL_MOTION, 8'h00);
        set_la(8'h80);
        mcu_u.wr(`ADDR_CTRL_POWER, 8'h00); settle(4);
        `CHK(la_out, 8'h40);
        mcu_u.wr(`ADDR_CTRL_POWER, 8'h20); settle(4);
        `CHK(la_out, 8'h20);
        mcu_u.wr(`ADDR_CTRL_POWER, 8'h30);
        set_la(8'hFF);
        settle(4); `CHK(la_out, 8'h20);
        mcu_u.step(1'b1); `CHK(la_out, 8'h3F);
        mcu_u.step(1'b0);
    endtask
    // live flags, parity, latched overloads, read-only and unmapped places
    task automatic t_stat;
        set_det(4'hB, 4'h0);
        settle(5); mcu_u.rd(`ADDR_FAULT_GENERAL, d); `CHK(d, 8'hCC);
        set_det(4'h4, 4'h0);
        settle(5); mcu_u.rd(`ADDR_FAULT_GENERAL, d); `CHK(d, 8'hA0);
        set_det(4'h0, 4'hA);
        settle(4);
        set_det(4'h0, 4'h0);
        settle(5); mcu_u.rd(`ADDR_OVERLOAD_X, d); `CHK(d, 8'h50);
        mcu_u.rd(`ADDR_OVERLOAD_X, d); `CHK(d, 8'h00);
        // a landed write would stick in the latched register
        mcu_u.wr(`ADDR_OVERLOAD_X, 8'hFF);
        mcu_u.rd(`ADDR_OVERLOAD_X, d); `CHK(d, 8'h00);
        mcu_u.rd(8'h3C, d); `CHK(d, 8'h00);
    endtask
    // hard reset in mid-run clears latched flags and written controls
    task automatic t_rst2;
        set_det(4'h0, 4'hF); settle(4);
        set_det(4'h0, 4'h0); settle(4);
        @(posedge clk) arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        mcu_u.rd(`ADDR_OVERLOAD_X, d); `CHK(d, 8'h00);
        mcu_u.rd(`ADDR_CTRL_POWER, d); `CHK(d, 8'h00);
        `CHK(peak_ma, 10'h00F);
    endtask
    // cycles from one chop-period pulse to the next
    task automatic period(output int n);
        int c;
        c = 0;
        while (pwm_st !== 1'b1 && c < 2000) begin @(negedge clk); c++; end
        @(negedge clk);
        n = 1;
        while (pwm_st !== 1'b1 && n < 2000) begin @(negedge clk); n++; end
    endtask
    task automatic t_pwm;
        int n;
        mcu_u.wr(`ADDR_CTRL_MOTION, 8'h00); period(n); period(n);
        `CHK(n, 32'h36D);
        mcu_u.wr(`ADDR_CTRL_MOTION, 8'h20); period(n); period(n);
        `CHK(n, 32'h1B6);
        mcu_u.wr(`ADDR_CTRL_MOTION, 8'h10); period(n); period(n);
        `CHK(n >= 32'h36D && n <= 32'h37C, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence; reset held ten cycles
    initial begin
        arst_n = 1'b0; {heat, pump, open_a, open_b} = 4'h0;
        ovl = 4'h0; la_raw = 8'h00; n_errors = 0; total_checks = 0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        t_reset(); t_power(); t_level(); t_slope(); t_dir();
        t_step(); t_la(); t_stat(); t_rst2(); t_pwm();
        final_report();
    end
    // watchdog well past the expected few thousand cycles
    initial begin
        #(30000 * 50);
        n_errors++;
        final_report();
    end
endmodule // stepper_config_status_tb
